// ---- src/sgmii_mdio_mgmt_regs.v ----
`include "sgmii_mgmt_regs.vh"

module sgmii_mdio_mgmt_regs (
  input  wire       sys_clk,       // core clock, 10 MHz
  input  wire       nrst,          // async reset, active low
  input  wire       mdc,           // management clock pin
  input  wire       mdio_in,       // management data pin, input side
  output reg        mdio_out,      // management data pin, output side
  output reg        mdio_oe_n,     // low while driving the data pin
  input  wire [4:0] phy_base,      // bits 4:2 select this core, 1:0 unused (frame address bits 1:0 pick the module)
  input  wire [3:0] link_up,       // current link state per module
  input  wire [3:0] an_complete,   // auto-negotiation done per module
  output reg  [3:0] module_reset,  // one-cycle soft reset per module
  output reg  [3:0] an_restart,    // one-cycle restart pulse per module
  output reg  [3:0] an_enable,     // auto-negotiation enabled per module
  output reg  [3:0] isolate,       // isolate from GMII per module
  output wire       power_down,    // module 0 transceiver low-power
  output wire [3:0] tx_unidir,     // transmit without valid link per module
  output reg  [3:0] disparity_en   // running disparity check per module
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_HDR  = 5'b00010;
  localparam ST_TA   = 5'b00100;
  localparam ST_DATA = 5'b01000;
  localparam ST_SKIP = 5'b10000;

  wire mdc_lvl;
  wire mdio_lvl;
  reg  mdc_prev;
  wire bit_rise;

  reg [4:0]  state;
  reg [4:0]  cnt;
  reg        prev_one;
  reg [11:0] hdr;
  reg        is_read;
  reg [1:0]  cur_mod;
  reg [4:0]  cur_reg;
  reg [15:0] rshift;
  reg [15:0] wshift;

  reg        wr_stb;
  reg [1:0]  wr_mod;
  reg [4:0]  wr_reg;
  reg [15:0] wr_data;
  reg        rd_stb;
  reg [1:0]  rd_mod;

  // storage copied per module
  reg [3:0] rsv14;
  reg [3:0] bit11;
  reg [3:0] unidir;
  reg [3:0] link_latch;

  wire [12:0] full_hdr;
  wire [1:0]  hdr_op;
  wire [4:0]  hdr_phy;
  wire [4:0]  hdr_reg;
  wire        hdr_ok;

  integer i;

  pin_sync #(
    .RESET_VAL (1'b0)
  ) u_mdc_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (mdc),
    .level   (mdc_lvl)
  );

  // idle data line is pulled high
  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_mdio_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (mdio_in),
    .level   (mdio_lvl)
  );

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_lvl;
    end
  end

  assign bit_rise = mdc_lvl & ~mdc_prev;

  // read value of one register of one module
  function [15:0] reg_value;
    input [1:0] m;
    input [4:0] a;
    begin
      case (a)
        `REG_CONTROL: begin
          reg_value = `ZERO16;
          reg_value[`CTL_RESET]      = 1'b0;
          reg_value[`CTL_RSV14]      = rsv14[m];
          reg_value[`CTL_SPEED_LSB]  = 1'b0;
          reg_value[`CTL_AN_ENABLE]  = an_enable[m];
          reg_value[`CTL_POWER_DOWN] = bit11[m];
          reg_value[`CTL_ISOLATE]    = isolate[m];
          reg_value[`CTL_AN_RESTART] = 1'b0;
          reg_value[`CTL_DUPLEX]     = 1'b1;
          reg_value[`CTL_COL_TEST]   = 1'b0;
          reg_value[`CTL_SPEED_MSB]  = 1'b1;
          reg_value[`CTL_UNIDIR]     = unidir[m];
        end
        `REG_STATUS: begin
          reg_value = `STATUS_FIXED;
          reg_value[`STS_AN_DONE] = an_complete[m];
          reg_value[`STS_LINK]    = link_latch[m];
        end
        `REG_ID_HIGH: begin
          reg_value = `ID_HIGH_VAL;
        end
        `REG_ID_LOW: begin
          reg_value = `ID_LOW_VAL;
        end
        `REG_EXT_STATUS: begin
          reg_value = `EXT_STATUS_VAL;
        end
        `REG_GENERIC: begin
          reg_value = `ZERO16;
          reg_value[`GEN_DISPARITY] = disparity_en[m];
        end
        default: begin
          reg_value = `ZERO16;
        end
      endcase
    end
  endfunction

  // frame bit counter, shared by every frame phase
  function [4:0] bump;
    input [4:0] c;
    begin
      bump = c + 5'h01;
    end
  endfunction

  // true on the rise that samples the last bit of a phase of n bits
  function last_bit;
    input [4:0] c;
    input [4:0] n;
    begin
      last_bit = (c == n - 5'h01);
    end
  endfunction

  // strobe aimed at module idx
  function mod_hit;
    input       stb;
    input [1:0] sel;
    input [1:0] idx;
    begin
      mod_hit = stb & (sel == idx);
    end
  endfunction

  assign full_hdr = {hdr, mdio_lvl};
  assign hdr_op   = full_hdr[11:10];
  assign hdr_phy  = full_hdr[9:5];
  assign hdr_reg  = full_hdr[4:0];
  // second start bit must be 1, opcode read or write, core address ours
  assign hdr_ok   = full_hdr[12] & ((hdr_op == `OP_READ) | (hdr_op == `OP_WRITE)) &
                    (hdr_phy[4:2] == phy_base[4:2]);

  // serial frame engine, one step per rising management clock
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      cnt       <= 5'h00;
      prev_one  <= 1'b0;
      hdr       <= 12'h000;
      is_read   <= 1'b0;
      cur_mod   <= 2'h0;
      cur_reg   <= 5'h00;
      rshift    <= 16'h0000;
      wshift    <= 16'h0000;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
      wr_stb    <= 1'b0;
      wr_mod    <= 2'h0;
      wr_reg    <= 5'h00;
      wr_data   <= 16'h0000;
      rd_stb    <= 1'b0;
      rd_mod    <= 2'h0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (bit_rise) begin
        case (state)
          ST_IDLE: begin
            // preamble may be suppressed: a single idle one is enough
            prev_one <= mdio_lvl;
            if (!mdio_lvl && prev_one) begin
              state <= ST_HDR;
              cnt   <= 5'h00;
            end
          end
          ST_HDR: begin
            hdr <= full_hdr[11:0];
            cnt <= bump(cnt);
            if (last_bit(cnt, `HDR_BITS)) begin
              cnt <= 5'h00;
              if (hdr_ok) begin
                state   <= ST_TA;
                is_read <= (hdr_op == `OP_READ);
                cur_mod <= hdr_phy[1:0];
                cur_reg <= hdr_reg;
                rshift  <= reg_value(hdr_phy[1:0], hdr_reg);
                if (hdr_op == `OP_READ) begin
                  rd_stb <= (hdr_reg == `REG_STATUS);
                  rd_mod <= hdr_phy[1:0];
                end
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_TA: begin
            // first rise drives the turnaround zero, the second the top data bit
            cnt <= bump(cnt);
            if (is_read) begin
              mdio_oe_n <= 1'b0;
              mdio_out  <= (cnt == 5'h00) ? 1'b0 : rshift[15];
            end
            if (last_bit(cnt, `TA_BITS)) begin
              state <= ST_DATA;
              cnt   <= 5'h00;
            end
          end
          ST_DATA: begin
            // output runs one bit ahead, the top bit left in turnaround
            cnt    <= bump(cnt);
            wshift <= {wshift[14:0], mdio_lvl};
            rshift <= {rshift[14:0], 1'b0};
            if (is_read) begin
              mdio_out <= rshift[14];
            end
            if (last_bit(cnt, `DATA_BITS)) begin
              state     <= ST_IDLE;
              prev_one  <= 1'b0;
              cnt       <= 5'h00;
              mdio_oe_n <= 1'b1;
              mdio_out  <= 1'b1;
              if (!is_read) begin
                wr_stb  <= 1'b1;
                wr_mod  <= cur_mod;
                wr_reg  <= cur_reg;
                wr_data <= {wshift[14:0], mdio_lvl};
              end
            end
          end
          ST_SKIP: begin
            // frame for another device: ride out its remaining bits
            cnt <= bump(cnt);
            if (last_bit(cnt, `SKIP_BITS)) begin
              state    <= ST_IDLE;
              prev_one <= 1'b0;
              cnt      <= 5'h00;
            end
          end
          default: begin
            state     <= ST_IDLE;
            cnt       <= 5'h00;
            mdio_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // register bank, one copy per module
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rsv14        <= {`NUM_MODULES{`RST_RSV14}};
      an_enable    <= {`NUM_MODULES{`RST_AN_ENABLE}};
      bit11        <= {`NUM_MODULES{`RST_BIT11}};
      isolate      <= {`NUM_MODULES{`RST_ISOLATE}};
      unidir       <= {`NUM_MODULES{`RST_UNIDIR}};
      disparity_en <= {`NUM_MODULES{`RST_DISPARITY}};
      link_latch   <= {`NUM_MODULES{`RST_LINK_LATCH}};
      module_reset <= 4'h0;
      an_restart   <= 4'h0;
    end else begin
      module_reset <= 4'h0;
      an_restart   <= 4'h0;
      for (i = 0; i < `NUM_MODULES; i = i + 1) begin
        // latches low on link loss, reloads the live state on a status register read
        if (mod_hit(rd_stb, rd_mod, i[1:0])) begin
          link_latch[i] <= link_up[i];
        end else begin
          link_latch[i] <= link_latch[i] & link_up[i];
        end
        if (mod_hit(wr_stb, wr_mod, i[1:0])) begin
          case (wr_reg)
            `REG_CONTROL: begin
              if (wr_data[`CTL_RESET]) begin
                // soft reset returns the module copy to defaults
                module_reset[i] <= 1'b1;
                rsv14[i]        <= `RST_RSV14;
                an_enable[i]    <= `RST_AN_ENABLE;
                bit11[i]        <= `RST_BIT11;
                isolate[i]      <= `RST_ISOLATE;
                unidir[i]       <= `RST_UNIDIR;
                disparity_en[i] <= `RST_DISPARITY;
              end else begin
                rsv14[i]     <= wr_data[`CTL_RSV14];
                an_enable[i] <= wr_data[`CTL_AN_ENABLE];
                isolate[i]   <= wr_data[`CTL_ISOLATE];
                unidir[i]    <= wr_data[`CTL_UNIDIR];
                an_restart[i] <= wr_data[`CTL_AN_RESTART];
                if (i == 0) begin
                  // writing 0 cannot wake the transceiver
                  bit11[i] <= bit11[i] | wr_data[`CTL_POWER_DOWN];
                end else begin
                  bit11[i] <= wr_data[`CTL_POWER_DOWN];
                end
              end
            end
            `REG_GENERIC: begin
              disparity_en[i] <= wr_data[`GEN_DISPARITY];
            end
            default: begin
              // constant, read-only and unmapped registers ignore writes
              rsv14[i] <= rsv14[i];
            end
          endcase
        end
      end
    end
  end

  assign power_down = bit11[0];
  // forcing only counts while auto-negotiation is off
  assign tx_unidir  = unidir & ~an_enable;
endmodule

// ---- src/sgmii_mgmt_regs.vh ----
`ifndef SGMII_MGMT_REGS_VH
`define SGMII_MGMT_REGS_VH
// Behaviour
// - every one of the four modules owns a full, independent copy of the management registers.
// - a read of any unassigned register address returns zero and a write to it does nothing.
// - addresses decode as 0 control, 1 status, 2 and 3 identifier, 15 extended status, 18 generic control.
// - generic control bit 0 is a read/write running disparity enable reset to 0, bits 15 to 1 read zero.
// - writing 1 to control bit 15 resets the addressed module and the bit reads back 0 afterwards.
// - control bit 14 is plain storage that reads back what was written, reset 0.
// - control bit 13 reads 0 and bit 6 reads 1, fixing the speed at 1000 Mb/s.
// - control bit 12 is a read/write auto-negotiation enable reset to 1.
// - on module 0 control bit 11 powers the transceiver down and only a module reset clears it.
// - modules 1 to 3 have their own self-clearing reset, no power-down, and bit 11 is plain storage.
// - control bit 10 isolates the module from the GMII side, reset 1.
// - writing 1 to control bit 9 restarts auto-negotiation unless bit 15 is written 1 in the same write, and the bit reads back 0 afterwards.
// - control bit 8 always reads 1 and bit 7 always reads 0.
// - control bit 5, reset 0, forces transmit without a valid link while auto-negotiation is off.
// - control bits 4 to 0 read zero and writes to them are ignored.

`define NUM_MODULES     4
`define NUM_MODULES_M1  3

// register addresses
`define REG_CONTROL     5'h00
`define REG_STATUS      5'h01
`define REG_ID_HIGH     5'h02
`define REG_ID_LOW      5'h03
`define REG_EXT_STATUS  5'h0f
`define REG_GENERIC     5'h12

// control bits
`define CTL_RESET       15
`define CTL_RSV14       14
`define CTL_SPEED_LSB   13
`define CTL_AN_ENABLE   12
`define CTL_POWER_DOWN  11
`define CTL_ISOLATE     10
`define CTL_AN_RESTART  9
`define CTL_DUPLEX      8
`define CTL_COL_TEST    7
`define CTL_SPEED_MSB   6
`define CTL_UNIDIR      5
`define GEN_DISPARITY   0

// status bits
`define STS_AN_DONE     5
`define STS_LINK        2

// reset values of stored bits
`define RST_RSV14       1'b0
`define RST_AN_ENABLE   1'b1
`define RST_BIT11       1'b0
`define RST_ISOLATE     1'b1
`define RST_UNIDIR      1'b0
`define RST_DISPARITY   1'b0
`define RST_LINK_LATCH  1'b0

// fixed register contents
`define STATUS_FIXED    16'h01c8
`define EXT_STATUS_VAL  16'h8000
// identifier value is arbitrary
`define ID_HIGH_VAL     16'h0000
`define ID_LOW_VAL      16'h0000
`define ZERO16          16'h0000

// management frame layout
`define OP_READ         2'b10
`define OP_WRITE        2'b01
`define HDR_BITS        5'h0d
`define TA_BITS         5'h02
`define DATA_BITS       5'h10
`define SKIP_BITS       5'h12
`endif

// ---- src/pin_sync.v ----
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire sys_clk, // core clock
  input  wire nrst,    // async reset, active low
  input  wire pin,     // raw pin level
  output reg  level    // filtered level
);
  reg s1;
  reg s2;
  reg s3;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1    <= RESET_VAL;
      s2    <= RESET_VAL;
      s3    <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// ---- verif/sgmii_mdio_mgmt_regs_checker.sv ----
module sgmii_mdio_mgmt_regs_checker (
  input logic       sys_clk, nrst, mdc, mdio_in, mdio_out, mdio_oe_n, power_down,
  input logic [4:0] phy_base,
  input logic [3:0] link_up, an_complete, module_reset, an_restart, an_enable, isolate, tx_unidir, disparity_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_reset_values: assert property ($rose(nrst) |-> mdio_oe_n && mdio_out && an_enable == 4'hf &&
    isolate == 4'hf && !power_down && disparity_en == 4'h0) else $error("outputs wrong after reset");
  a_reset_pulse: assert property (module_reset != 4'h0 |=> module_reset == 4'h0)
    else $error("module reset longer than one cycle");
  a_restart_pulse: assert property (an_restart != 4'h0 |=> an_restart == 4'h0)
    else $error("restart longer than one cycle");
  a_restart_excl: assert property ((an_restart & module_reset) == 4'h0)
    else $error("restart together with module reset");
  a_soft_defaults: assert property (module_reset[0] |-> ##[0:2] (an_enable[0] && isolate[0] &&
    !power_down && !disparity_en[0] && !tx_unidir[0])) else $error("module reset left values");
  a_unidir_gate: assert property ((tx_unidir & an_enable) == 4'h0)
    else $error("unidirectional with negotiation on");
  a_pd_clear: assert property ($fell(power_down) |-> module_reset[0])
    else $error("power down cleared without reset");
  a_ta_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_idle_high: assert property (mdio_oe_n |-> mdio_out)
    else $error("released pin not high");
  c_soft_reset: cover property (module_reset[0]);
  c_power_down: cover property (power_down);
  c_read_drive: cover property ($fell(mdio_oe_n));
endmodule
bind sgmii_mdio_mgmt_regs sgmii_mdio_mgmt_regs_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .mdc(mdc),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .power_down(power_down), .phy_base(phy_base),
  .link_up(link_up), .an_complete(an_complete), .module_reset(module_reset), .an_restart(an_restart),
  .an_enable(an_enable), .isolate(isolate), .tx_unidir(tx_unidir), .disparity_en(disparity_en));

// ---- verif/mdio_station.sv ----
module mdio_station (
  input  logic sys_clk,   // core clock
  output logic mdc,       // management clock
  output logic mdio_in,   // resolved data line
  input  logic mdio_out,  // device data
  input  logic mdio_oe_n  // device drive, low active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv, drv_en;
  // pull-up holds the line high when nobody drives
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
  end
  // one bit is 16 core cycles, well under the filter limit
  task automatic bitx(input logic b, input logic en, output logic s);
    @(negedge sys_clk);
    mdc = 1'b0;
    drv = b;
    drv_en = en;
    repeat (7) @(negedge sys_clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  // short preamble, then header, turnaround, data and one idle bit
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [19:0] hdr;
    logic        s;
    integer      i;
    hdr = {4'hf, 2'b01, op, pa, ra, (op == 2'b01) ? 2'b10 : 2'b11};
    for (i = 19; i >= 0; i--) bitx(hdr[i], !(op != 2'b01 && i < 2), s);
    for (i = 15; i >= 0; i--) begin
      bitx(wd[i], op == 2'b01, s);
      rd[i] = s;
    end
    bitx(1'b1, 1'b0, s);
    mdc = 1'b0;
  endtask
endmodule

// ---- verif/test_sgmii_mdio_mgmt_regs.sv ----
module test_sgmii_mdio_mgmt_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, nrst, mdc, mdio_in, mdio_out, mdio_oe_n, power_down;
  logic [4:0] phy_base;
  logic [3:0] link_up, an_complete, module_reset, an_restart, an_enable, isolate, tx_unidir, disparity_en;
  logic [15:0] r;
  logic [2:0]  base;
  integer mismatches, n_tests, i, j, k, m;
  integer ctl[4], gen[4], lat[4], rst_exp[4], rst_got[4], rs_exp[4], rs_got[4];
  sgmii_mdio_mgmt_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .phy_base(phy_base), .link_up(link_up), .an_complete(an_complete),
    .module_reset(module_reset), .an_restart(an_restart), .an_enable(an_enable), .isolate(isolate),
    .power_down(power_down), .tx_unidir(tx_unidir), .disparity_en(disparity_en));
  mdio_station u_sta (.sys_clk(sys_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    for (j = 0; j < 4; j++) begin
      if (module_reset[j] === 1'b1) rst_got[j]++;
      if (an_restart[j] === 1'b1) rs_got[j]++;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [15:0] expv(input integer m, input logic [4:0] a);
    case (a)
      5'h00: expv = ctl[m] | 16'h0140;
      5'h01: expv = 16'h01c8 | (an_complete[m] << 5) | (lat[m] << 2);
      5'h0f: expv = 16'h8000;
      5'h12: expv = gen[m];
      default: expv = 16'h0000;
    endcase
  endfunction
  task rchk(input integer m, input logic [4:0] a);
    logic [15:0] v, e;
    e = expv(m, a);
    u_sta.frame(2'b10, {base, m[1:0]}, a, 16'h0000, v);
    chk(v, e);
    if (a == 5'h01) lat[m] = link_up[m];
  endtask
  task wr(input integer m, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_sta.frame(2'b01, {base, m[1:0]}, a, d, x);
    if (a == 5'h12) gen[m] = d[0];
    if (a == 5'h00 && d[15]) begin
      ctl[m] = 16'h1400;
      gen[m] = 0;
      rst_exp[m]++;
    end else if (a == 5'h00) begin
      if (d[9]) rs_exp[m]++;
      // module 0 power down is sticky until a module reset
      ctl[m] = (d & 16'h5c20) | ((m == 0) ? (ctl[0] & 16'h0800) : 0);
    end
  endtask
  task outs;
    for (k = 0; k < 4; k++) begin
      chk({12'h0, an_enable[k], isolate[k], disparity_en[k]}, {12'h0, ctl[k][12], ctl[k][10], gen[k][0]});
      chk({15'h0, tx_unidir[k]}, {15'h0, ctl[k][5] & !ctl[k][12]});
      chk(rst_got[k], rst_exp[k]);
      chk(rs_got[k], rs_exp[k]);
    end
    chk({15'h0, power_down}, {15'h0, ctl[0][11]});
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
  initial begin
    nrst = 1'b0;
    phy_base = 5'h00;
    link_up = 4'h0;
    an_complete = 4'h0;
    mismatches = 0;
    n_tests = 0;
    for (k = 0; k < 4; k++) begin
      ctl[k] = 16'h1400;
      {gen[k], lat[k], rst_exp[k], rst_got[k], rs_exp[k], rs_got[k]} = 0;
    end
    void'($urandom(32'hf026c7a7));
    base = $urandom;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    phy_base = {base, 2'b00};
    link_up = $urandom;
    an_complete = $urandom;
    repeat (6) @(negedge sys_clk);
    outs;
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 2; i++) rchk(k, 5'h01);
      rchk(k, 5'h00);
      rchk(k, 5'h12);
      rchk(k, 5'h02);
      rchk(k, 5'h03);
      rchk(k, 5'h0f);
      rchk(k, 5'h04 + k);
      rchk(k, 5'h13 + k);
    end
    wr(0, 5'h00, 16'h0800);
    wr(0, 5'h00, 16'h001f);
    wr(1, 5'h00, 16'h0800);
    wr(1, 5'h00, 16'h0000);
    outs;
    rchk(0, 5'h00);
    rchk(1, 5'h00);
    wr(0, 5'h00, 16'h8000);
    outs;
    rchk(0, 5'h00);
    m = $urandom % 4;
    wr(m, 5'h01, $urandom);
    wr(m, 5'h0f, $urandom);
    wr(m, 5'h14, $urandom);
    rchk(m, 5'h0f);
    rchk(m, 5'h14);
    for (i = 0; i < 12; i++) begin
      m = $urandom % 4;
      wr(m, 5'h00, $urandom);
      wr(m, 5'h12, $urandom);
      outs;
      rchk(m, 5'h00);
      rchk(m, 5'h12);
      rchk((m + 1) % 4, 5'h00);
    end
    u_sta.frame(2'b10, {base + 3'd1, 2'd0}, 5'h00, 16'h0000, r);
    chk(r, 16'hffff);
    u_sta.frame(2'b11, {base, 2'd1}, 5'h00, 16'h0000, r);
    chk(r, 16'hffff);
    u_sta.frame(2'b01, {~base, 2'd0}, 5'h00, 16'h8a00, r);
    rchk(0, 5'h00);
    outs;
    give_verdict;
  end
endmodule
